// [logic/fpsi_front_panel.sv]
// front panel pushbutton handling and status lamp drive
// Summary of operation
// [R1] A reset press resets the whole board and also drives backplane system reset when system controller.
// [R2] A software control disables the reset button so that a press then has no effect.
// [R3] When enabled, an abort press raises an interrupt at the software-programmed level.
// [R4] The fail lamp follows the board failure line.
// [R5] The status lamp lights when the processor status outputs decode as halted.
// [R6] The run lamp lights while the active-low transfer in progress line is low.
// [R7] The system controller lamp lights while the board is backplane system controller.
// [R8] The network lamp lights while the network controller is local bus master.
// [R9] The disk bus lamp lights while the disk bus controller is local bus master.
// [R10] The backplane lamp lights while the board drives address strobe or serves an inbound backplane access.
// [R11] The subsystem lamp lights while the board drives its strobe or serves an inbound subsystem access.
// [R12] Buttons are synchronised and debounced so one press gives exactly one event.
`timescale 1ns/1ps
`include "fpsi_defines.svh"

module fpsi_front_panel
    import fpsi_pkg::*;
#(
    parameter int DEBOUNCE_CYC = `FPSI_DEBOUNCE_CYC
) (
    input  wire logic                    clk_i,
    input  wire logic                    resetn_i,
    input  wire logic                    reset_btn_n_i,
    input  wire logic                    abort_btn_n_i,
    input  wire logic                    reset_btn_disable_i,
    input  wire logic                    abort_enable_i,
    input  wire logic [`FPSI_LVL_W-1:0]  abort_level_i,
    input  wire logic                    abort_ack_i,
    input  wire fpsi_cond_t              cond_i,
    output logic                         board_reset_o,
    output logic                         sysreset_drive_o,
    output logic                         abort_irq_o,
    output logic [`FPSI_LVL_W-1:0]       abort_irq_level_o,
    output fpsi_lamps_t                  lamps_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic is_halted(input logic [`FPSI_STAT_W-1:0] st);
        return st == `FPSI_HALT_CODE;
    endfunction : is_halted

    // ************************************************************
    // pushbutton synchronisers
    // ************************************************************
    logic [1:0] rst_sync_q;
    logic [1:0] abt_sync_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_sync_q <= 2'h0;
            abt_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], ~reset_btn_n_i}; // R12
            abt_sync_q <= {abt_sync_q[0], ~abort_btn_n_i}; // R12
        end
    end

    // ************************************************************
    // debounce: a level must hold steady for the settle time
    // ************************************************************
    logic [`FPSI_CNT_W-1:0] rst_cnt_q;
    logic [`FPSI_CNT_W-1:0] abt_cnt_q;
    logic                   rst_stable_q;
    logic                   abt_stable_q;
    logic                   rst_stable_d;
    logic                   abt_stable_d;

    always_comb begin
        rst_stable_d = rst_stable_q;
        abt_stable_d = abt_stable_q;
        if (rst_cnt_q == `FPSI_CNT_W'(DEBOUNCE_CYC - 1)) begin
            rst_stable_d = rst_sync_q[1];
        end
        if (abt_cnt_q == `FPSI_CNT_W'(DEBOUNCE_CYC - 1)) begin
            abt_stable_d = abt_sync_q[1];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_cnt_q    <= '0;
            rst_stable_q <= 1'b0;
        end else begin
            // bounce restarts the count, so chatter never yields a second edge
            if (rst_sync_q[1] == rst_stable_q) begin
                rst_cnt_q <= '0; // R12
            end else if (rst_cnt_q != `FPSI_CNT_W'(DEBOUNCE_CYC - 1)) begin
                rst_cnt_q <= rst_cnt_q + 1'b1;
            end else begin
                rst_cnt_q <= '0;
            end
            rst_stable_q <= rst_stable_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            abt_cnt_q    <= '0;
            abt_stable_q <= 1'b0;
        end else begin
            if (abt_sync_q[1] == abt_stable_q) begin
                abt_cnt_q <= '0; // R12
            end else if (abt_cnt_q != `FPSI_CNT_W'(DEBOUNCE_CYC - 1)) begin
                abt_cnt_q <= abt_cnt_q + 1'b1;
            end else begin
                abt_cnt_q <= '0;
            end
            abt_stable_q <= abt_stable_d;
        end
    end

    logic rst_press;
    logic abt_press;
    assign rst_press = rst_stable_d & ~rst_stable_q; // R12
    assign abt_press = abt_stable_d & ~abt_stable_q; // R12

    // ************************************************************
    // reset pulse generator
    // ************************************************************
    fpsi_rst_state_t          rst_state_q;
    logic [`FPSI_RST_CNT_W-1:0] pulse_cnt_q;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rst_state_q      <= FPSI_RST_IDLE;
            pulse_cnt_q      <= '0;
            board_reset_o    <= 1'b0;
            sysreset_drive_o <= 1'b0;
        end else begin
            unique case (rst_state_q)
                FPSI_RST_IDLE: begin
                    if (rst_press && !reset_btn_disable_i) begin // R2
                        rst_state_q      <= FPSI_RST_PULSE;
                        pulse_cnt_q      <= '0;
                        board_reset_o    <= 1'b1; // R1
                        sysreset_drive_o <= cond_i.is_system_controller; // R1
                    end
                end
                FPSI_RST_PULSE: begin
                    if (pulse_cnt_q == `FPSI_RST_CNT_W'(`FPSI_RST_PULSE_CYC - 1)) begin
                        rst_state_q      <= FPSI_RST_WAIT_REL;
                        board_reset_o    <= 1'b0;
                        sysreset_drive_o <= 1'b0;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q + 1'b1;
                    end
                end
                FPSI_RST_WAIT_REL: begin
                    // one pulse per press: wait for the button to be let go
                    if (!rst_stable_q) begin
                        rst_state_q <= FPSI_RST_IDLE; // R12
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // abort interrupt
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            abort_irq_o       <= 1'b0;
            abort_irq_level_o <= '0;
        end else begin
            // a new press beats a simultaneous acknowledge
            if (abt_press && abort_enable_i) begin
                abort_irq_o       <= 1'b1; // R3
                abort_irq_level_o <= abort_level_i; // R3
            end else if (abort_ack_i || !abort_enable_i) begin
                abort_irq_o <= 1'b0;
            end
        end
    end

    // ************************************************************
    // status lamps
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            lamps_o <= '0;
        end else begin
            lamps_o.fail_lamp              <= cond_i.board_failure_line; // R4
            lamps_o.status_lamp            <= is_halted(cond_i.cpu_status); // R5
            lamps_o.run_lamp               <= ~cond_i.transfer_in_progress_n; // R6
            lamps_o.system_controller_lamp <= cond_i.is_system_controller; // R7
            lamps_o.lan_lamp               <= cond_i.lan_master; // R8
            lamps_o.scsi_lamp              <= cond_i.scsi_master; // R9
            lamps_o.vme_lamp               <= cond_i.vme_as_driven | cond_i.vme_inbound_master; // R10
            lamps_o.vsb_lamp               <= cond_i.vsb_pas_driven | cond_i.vsb_inbound_master; // R11
        end
    end

endmodule : fpsi_front_panel

// [inc/fpsi_defines.svh]
// constants for the front panel switch and lamp block
`ifndef FPSI_DEFINES_SVH
`define FPSI_DEFINES_SVH

// debounce settle time in ns and derived cycles at 100 MHz
`define FPSI_CLK_PERIOD_NS   10
`define FPSI_DEBOUNCE_NS     100000
`define FPSI_DEBOUNCE_CYC    (`FPSI_DEBOUNCE_NS / `FPSI_CLK_PERIOD_NS)
`define FPSI_CNT_W           14
// reset pulse length driven on board and backplane
`define FPSI_RST_PULSE_NS    2000
`define FPSI_RST_PULSE_CYC   (`FPSI_RST_PULSE_NS / `FPSI_CLK_PERIOD_NS)
`define FPSI_RST_CNT_W       8
// processor status code meaning halted
`define FPSI_HALT_CODE       3'h7
`define FPSI_STAT_W          3
`define FPSI_LVL_W           3

`endif

// [inc/fpsi_pkg.sv]
// types for the front panel switch and lamp block
package fpsi_pkg;

    typedef struct packed {
        logic board_failure_line;
        logic [2:0] cpu_status;
        logic transfer_in_progress_n;
        logic is_system_controller;
        logic lan_master;
        logic scsi_master;
        logic vme_as_driven;
        logic vme_inbound_master;
        logic vsb_pas_driven;
        logic vsb_inbound_master;
    } fpsi_cond_t;

    typedef struct packed {
        logic fail_lamp;
        logic status_lamp;
        logic run_lamp;
        logic system_controller_lamp;
        logic lan_lamp;
        logic scsi_lamp;
        logic vme_lamp;
        logic vsb_lamp;
    } fpsi_lamps_t;

    typedef enum logic [1:0] {
        FPSI_RST_IDLE,
        FPSI_RST_PULSE,
        FPSI_RST_WAIT_REL
    } fpsi_rst_state_t;

endpackage : fpsi_pkg

// [tb/fpsi_front_panel_sva.sv]
// assertion checker for the front panel block
`timescale 1ns/1ps
`include "fpsi_defines.svh"
module fpsi_front_panel_sva
    import fpsi_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        abort_enable_i,
    input wire fpsi_cond_t  cond_i,
    input wire logic        board_reset_o,
    input wire logic        sysreset_drive_o,
    input wire logic        abort_irq_o,
    input wire fpsi_lamps_t lamps_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // lamps lag one edge, so skip the edge right after reset
    sequence s_live; $past(resetn_i); endsequence
    sequence s_rst_rise; $rose(board_reset_o); endsequence
    a_fail_lamp: assert property (s_live |-> lamps_o.fail_lamp == $past(cond_i.board_failure_line))
        else $error("fail lamp wrong");
    a_halt_lamp: assert property (s_live |-> lamps_o.status_lamp == ($past(cond_i.cpu_status) == `FPSI_HALT_CODE))
        else $error("status lamp wrong");
    a_run_lamp: assert property (s_live |-> lamps_o.run_lamp != $past(cond_i.transfer_in_progress_n))
        else $error("run lamp wrong");
    a_system_controller_lamp_lamp: assert property (s_live |-> lamps_o.system_controller_lamp == $past(cond_i.is_system_controller))
        else $error("controller lamp wrong");
    a_lan_lamp: assert property (s_live |-> lamps_o.lan_lamp == $past(cond_i.lan_master))
        else $error("network lamp wrong");
    a_scsi_lamp: assert property (s_live |-> lamps_o.scsi_lamp == $past(cond_i.scsi_master))
        else $error("disk lamp wrong");
    a_vme_lamp: assert property (s_live |-> lamps_o.vme_lamp == $past(cond_i.vme_as_driven | cond_i.vme_inbound_master))
        else $error("backplane lamp wrong");
    a_vsb_lamp: assert property (s_live |-> lamps_o.vsb_lamp == $past(cond_i.vsb_pas_driven | cond_i.vsb_inbound_master))
        else $error("subsystem lamp wrong");
    a_sysrst_with_board: assert property (sysreset_drive_o |-> board_reset_o)
        else $error("backplane reset without board reset");
    a_rst_pulse_held: assert property (s_rst_rise |-> board_reset_o [*8])
        else $error("reset pulse too short");
    a_irq_gated_off: assert property (s_live and !$past(abort_enable_i) |-> !abort_irq_o)
        else $error("interrupt while disabled");
endmodule : fpsi_front_panel_sva
bind fpsi_front_panel fpsi_front_panel_sva i_fpsi_front_panel_sva (.clk_i(clk_i), .resetn_i(resetn_i),
    .abort_enable_i(abort_enable_i), .cond_i(cond_i), .board_reset_o(board_reset_o),
    .sysreset_drive_o(sysreset_drive_o), .abort_irq_o(abort_irq_o), .lamps_o(lamps_o));

// [tb/fpsi_panel_model.sv]
// pushbutton partner with contact bounce
`timescale 1ns/1ps
module fpsi_panel_model (
    input  wire logic clk_i,
    output logic      reset_btn_n_o,
    output logic      abort_btn_n_o
);
    initial begin
        reset_btn_n_o = 1'b1;
        abort_btn_n_o = 1'b1;
    end
    // one-cycle chatter on make and break, shorter than the debounce window
    task automatic press(input bit abt, input int hold);
        logic lv;
        for (int i = 0; i < hold + 8; i++) begin
            @(negedge clk_i);
            lv = (i < 4) ? i[0] : (i < hold + 4) ? 1'b0 : !i[0];
            if (abt) abort_btn_n_o = lv;
            else reset_btn_n_o = lv;
        end
        @(negedge clk_i);
        if (abt) abort_btn_n_o = 1'b1;
        else reset_btn_n_o = 1'b1;
    endtask : press
endmodule : fpsi_panel_model

// [tb/fpsi_front_panel_tb_top.sv]
// self-checking bench for the front panel block
`timescale 1ns/1ps
`include "fpsi_defines.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module fpsi_front_panel_tb_top;
    import fpsi_pkg::*;
    logic                   clk_i = 1'b0, resetn_i = 1'b0, rst_dis = 1'b0, abt_en = 1'b0, ack = 1'b0;
    logic [`FPSI_LVL_W-1:0] lvl = '0, irq_lvl;
    logic                   rbtn_n, abtn_n, brst, srst, irq;
    fpsi_cond_t             cond = 12'h080;
    fpsi_lamps_t            lamps;
    int                     failures = 0, cmp_count = 0;
    always #5 clk_i = ~clk_i;
    fpsi_panel_model i_fpsi_panel_model (.clk_i(clk_i), .reset_btn_n_o(rbtn_n), .abort_btn_n_o(abtn_n));
    fpsi_front_panel #(.DEBOUNCE_CYC(4)) i_fpsi_front_panel (.clk_i(clk_i), .resetn_i(resetn_i),
        .reset_btn_n_i(rbtn_n), .abort_btn_n_i(abtn_n), .reset_btn_disable_i(rst_dis), .abort_enable_i(abt_en),
        .abort_level_i(lvl), .abort_ack_i(ack), .cond_i(cond), .board_reset_o(brst), .sysreset_drive_o(srst),
        .abort_irq_o(irq), .abort_irq_level_o(irq_lvl), .lamps_o(lamps));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task automatic t_lamps();
        fpsi_lamps_t ex;
        for (int i = 0; i < 13; i++) begin
            @(negedge clk_i);
            cond = (i == 12) ? 12'h780 : 12'h080 ^ (12'h001 << i);
            ex = {cond.board_failure_line, cond.cpu_status == `FPSI_HALT_CODE, !cond.transfer_in_progress_n,
                  cond.is_system_controller, cond.lan_master, cond.scsi_master,
                  cond.vme_as_driven | cond.vme_inbound_master, cond.vsb_pas_driven | cond.vsb_inbound_master};
            @(negedge clk_i);
            `CHK(lamps, ex)
        end
        $display("lamp test done");
    endtask : t_lamps
    task automatic t_reset(input bit sc, input bit dis);
        int len, slen, rises;
        logic prev;
        len = 0; slen = 0; rises = 0; prev = 1'b0;
        @(negedge clk_i);
        cond.is_system_controller = sc;
        rst_dis = dis;
        fork i_fpsi_panel_model.press(1'b0, 20); join_none
        // long enough for press, debounce, the full pulse and the release
        repeat (300) begin
            @(negedge clk_i);
            len += brst;
            slen += srst;
            rises += (brst && !prev);
            prev = brst;
        end
        `CHK(rises, dis ? 0 : 1)
        `CHK(dis ? len == 0 : (len >= 200 && len <= 201), 1'b1)
        `CHK(slen, sc ? len : 0)
        $display("reset test done");
    endtask : t_reset
    task automatic t_abort(input bit en, input logic [2:0] l);
        @(negedge clk_i);
        abt_en = en;
        lvl = l;
        i_fpsi_panel_model.press(1'b1, 10);
        lvl = ~l;
        repeat (3) @(negedge clk_i);
        `CHK(irq, en)
        if (en) `CHK(irq_lvl, l)
        if (l[0]) abt_en = 1'b0;
        else ack = 1'b1;
        @(negedge clk_i);
        ack = 1'b0;
        repeat (8) @(negedge clk_i);
        `CHK(irq, 1'b0)
        $display("abort test done");
    endtask : t_abort
    initial begin
        repeat (10) @(negedge clk_i);
        resetn_i = 1'b1;
        t_lamps();
        t_reset(1'b1, 1'b0);
        t_reset(1'b0, 1'b0);
        t_reset(1'b1, 1'b1);
        for (int i = 0; i < 8; i++) t_abort(1'b1, i[2:0]);
        t_abort(1'b0, 3'h5);
        report_and_stop();
    end
    initial begin
        #50000;
        failures++;
        report_and_stop();
    end
endmodule : fpsi_front_panel_tb_top
